/* File: rtl/lrss_consts.vh */
`ifndef LRSS_CONSTS_VH
`define LRSS_CONSTS_VH
`define LRSS_SEL_ADDR 8'hFD
`define LRSS_CODE_NOP 8'h00
`define LRSS_CODE_FRAME_FIRST 8'h01
`define LRSS_CODE_FRAME_LAST 8'h24
`define LRSS_CODE_SET_FIRST 8'h40
`define LRSS_CODE_SET_LAST 8'h45
`define LRSS_CODE_DOTCORR 8'h80
`define LRSS_CODE_CTRL 8'hC0
`define LRSS_SEC_NONE 3'h0
`define LRSS_SEC_FRAME 3'h1
`define LRSS_SEC_SET 3'h2
`define LRSS_SEC_DOTCORR 3'h3
`define LRSS_SEC_CTRL 3'h4
`define LRSS_CFG_MEM_LSB 0
`define LRSS_CFG_MEM_MSB 2
`define LRSS_CFG_DC_BIT 4
`define LRSS_FRAMES_MAX 6'h24
`define LRSS_FRAMES_PER_SET 6'h06
`define LRSS_PWM_ADDR 8'h01
`define LRSS_PWM_MSB 7
`define LRSS_PWM_LSB 5
`endif

/* File: rtl/lrss_section_select.v */
// Functional notes
// R1: selection register picks the addressed memory section
// R2: selection holds until a new code arrives
// R3: decode nop, frames, sets, dot correction, control
// R4: frame combines on/off data with a set
// R5: frame names its set; device applies it
// R6: layout n gives n sets, fewer frames
// R7: host programs layout before frame data
// R8: layout in config bits 2:0, dot bit 4
// R9: first frame write locks layout until reset
// R10: host rewrites frames after layout change
// R11: command byte addresses within selected section
// R12: segment zero byte one bits 7:5 hold set
// R13: undefined or out-of-layout codes are ignored
`timescale 1ns/1ps
`default_nettype none
`include "lrss_consts.vh"
module lrss_section_select
#(
	// depth of the per-frame set reference store
	parameter FRAMES = 36
)
(
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// decoded register write from the serial interface
	input wire wr_stb,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	// config register write (layout fields)
	input wire cfg_wr,
	input wire [7:0] cfg_data,
	// displayed frame index for set lookup
	input wire [5:0] show_frame,
	// selection state
	output reg [2:0] sec_kind,
	output reg [5:0] sec_index,
	output reg [7:0] sec_addr,
	output reg sec_wr,
	output reg [7:0] sec_wdata,
	// layout state
	output reg [2:0] mem_conf,
	output reg dc_enable,
	output reg layout_locked,
	output reg [5:0] frame_count,
	output reg [2:0] set_count,
	// set applied to the shown frame
	output reg [2:0] show_set
);
	// layout capacity and decode terms
	reg [2:0] frame_set [0:FRAMES-1];
	reg [2:0] next_mem_conf;
	reg [2:0] sets_avail;
	reg [7:0] frames_used;
	reg [7:0] frames_full;
	reg [5:0] frames_avail;
	reg [2:0] cfg_mem;
	reg sel_hit;
	reg frame_wr;
	reg [7:0] frame_off;
	reg [7:0] set_off;
	reg [2:0] next_kind;
	reg [5:0] next_index;
	reg next_valid;
	reg [2:0] show_ref;
	reg show_ok;
	genvar g;

	// sets = n, frames = 36 - 6(n-1), minus one with dot correction
	always @*
	begin
		next_mem_conf = mem_conf;
		if (mem_conf == 3'h0 || mem_conf > 3'h6)
			next_mem_conf = 3'h1;
		sets_avail = next_mem_conf; // [R6]
		frames_used = {5'h00, next_mem_conf - 3'h1}
			* {2'h0, `LRSS_FRAMES_PER_SET};
		frames_full = {2'h0, `LRSS_FRAMES_MAX} - frames_used
			- {7'h00, dc_enable}; // [R6]
		frames_avail = frames_full[5:0];
	end

	always @*
	begin
		cfg_mem = cfg_data[`LRSS_CFG_MEM_MSB:`LRSS_CFG_MEM_LSB]; // [R8]
		sel_hit = wr_stb && (wr_addr == `LRSS_SEL_ADDR); // [R1]
		frame_wr = wr_stb && !sel_hit && (sec_kind == `LRSS_SEC_FRAME);
		frame_off = wr_data - `LRSS_CODE_FRAME_FIRST;
		set_off = wr_data - `LRSS_CODE_SET_FIRST;
		next_kind = sec_kind;
		next_index = sec_index;
		next_valid = 1'b0;
		// codes compared whole; near misses such as 0x25 fall through
		// [R3] [R13]
		if (wr_data >= `LRSS_CODE_FRAME_FIRST &&
			wr_data <= `LRSS_CODE_FRAME_LAST)
		begin
			if (frame_off[5:0] < frames_avail)
			begin
				next_kind = `LRSS_SEC_FRAME;
				next_index = frame_off[5:0];
				next_valid = 1'b1;
			end
		end
		else if (wr_data >= `LRSS_CODE_SET_FIRST &&
			wr_data <= `LRSS_CODE_SET_LAST)
		begin
			if (set_off[2:0] < sets_avail)
			begin
				next_kind = `LRSS_SEC_SET;
				next_index = {3'h0, set_off[2:0]};
				next_valid = 1'b1;
			end
		end
		else if (wr_data == `LRSS_CODE_DOTCORR)
		begin
			next_kind = `LRSS_SEC_DOTCORR;
			next_index = 6'h00;
			next_valid = 1'b1;
		end
		else if (wr_data == `LRSS_CODE_CTRL)
		begin
			next_kind = `LRSS_SEC_CTRL;
			next_index = 6'h00;
			next_valid = 1'b1;
		end
	end

	// out-of-range frames read no entry, so no unknown leaks out
	always @*
	begin
		show_ref = 3'h0;
		show_ok = 1'b0;
		if (show_frame < frames_avail)
		begin
			show_ref = frame_set[show_frame];
			show_ok = (show_ref < sets_avail);
		end
	end

	// one store per frame; reset clears every set reference
	generate
		for (g = 0; g < FRAMES; g = g + 1)
		begin : g_frame
			localparam [5:0] IDX = g;
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
					frame_set[g] <= 3'h0;
				else if (frame_wr && sec_index == IDX &&
					wr_addr == `LRSS_PWM_ADDR)
					frame_set[g] <=
						wr_data[`LRSS_PWM_MSB:`LRSS_PWM_LSB]; // [R12] [R5]
			end
		end
	endgenerate

	// lock taken only after this write; frozen while locked
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			mem_conf <= 3'h1;
			dc_enable <= 1'b0;
			layout_locked <= 1'b0; // [R9]
		end
		else
		begin
			if (frame_wr)
				layout_locked <= 1'b1; // [R9]
			// a cfg write in the locking cycle still lands
			if (cfg_wr && !layout_locked) // [R9] [R7]
			begin
				mem_conf <= (cfg_mem == 3'h0 || cfg_mem > 3'h6) ?
					3'h1 : cfg_mem;
				dc_enable <= cfg_data[`LRSS_CFG_DC_BIT]; // [R8]
			end
		end
	end

	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sec_kind <= `LRSS_SEC_NONE;
			sec_index <= 6'h00;
			sec_addr <= 8'h00;
			sec_wr <= 1'b0;
			sec_wdata <= 8'h00;
			frame_count <= 6'h24;
			set_count <= 3'h1;
			show_set <= 3'h0;
		end
		else
		begin
			// one-cycle strobe; a sink cannot stall it
			sec_wr <= 1'b0;
			frame_count <= frames_avail;
			set_count <= sets_avail;
			// selection persists otherwise [R2]
			if (sel_hit && next_valid)
			begin
				sec_kind <= next_kind; // [R1]
				sec_index <= next_index;
			end
			// other addresses are offsets in the section [R11]
			if (wr_stb && !sel_hit && sec_kind != `LRSS_SEC_NONE)
			begin
				sec_addr <= wr_addr;
				sec_wdata <= wr_data;
				sec_wr <= 1'b1;
			end
			// frame reuses a shared set; set 0 outside layout [R4] [R5]
			show_set <= show_ok ? show_ref : 3'h0;
		end
	end
endmodule // lrss_section_select
`default_nettype wire

/* File: tb/lrss_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lrss_chk(
	input wire ref_clk,
	input wire reset,
	input wire wr_stb,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire cfg_wr,
	input wire [2:0] sec_kind,
	input wire sec_wr,
	input wire [2:0] mem_conf,
	input wire layout_locked
);
	wire sel = wr_stb && wr_addr == 8'hFD;
	wire inw = wr_stb && wr_addr != 8'hFD;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_sel_frame: assert property (sel && wr_data == 8'h01 |=>
		sec_kind == 3'h1) else $error("frame select");
	a_sel_ctrl: assert property (sel && wr_data == 8'hC0 |=>
		sec_kind == 3'h4) else $error("ctrl select");
	a_sel_hold: assert property (!sel |=> $stable(sec_kind))
		else $error("select moved");
	a_nop_keep: assert property (sel && wr_data == 8'h00 |=>
		$stable(sec_kind)) else $error("nop moved");
	a_wr_pass: assert property (inw && sec_kind != 3'h0 |=> sec_wr)
		else $error("write lost");
	a_lock_set: assert property (inw && sec_kind == 3'h1 |=>
		layout_locked) else $error("no lock");
	a_lock_hold: assert property (layout_locked |=> layout_locked[*3])
		else $error("lock dropped");
	a_lock_cfg: assert property (layout_locked && cfg_wr |=>
		$stable(mem_conf)) else $error("layout moved");
	c_lock: cover property (layout_locked && cfg_wr);
	c_set: cover property (sel && wr_data == 8'h40);
	c_wr: cover property (sec_wr);
endmodule // lrss_chk
bind lrss_section_select lrss_chk u_chk(.ref_clk(ref_clk), .reset(reset),
	.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .cfg_wr(cfg_wr),
	.sec_kind(sec_kind), .sec_wr(sec_wr), .mem_conf(mem_conf),
	.layout_locked(layout_locked));
`default_nettype wire

/* File: tb/lrss_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lrss_host(
	input wire ref_clk,
	output logic stb,
	output logic [7:0] a,
	output logic [7:0] d
);
	initial stb = 0;
	task wr(input logic [7:0] wa, input logic [7:0] wd);
		@(negedge ref_clk);
		stb = 1;
		a = wa;
		d = wd;
		@(negedge ref_clk);
		stb = 0;
		a = ~wa; // released bus must not look valid
		d = ~wd;
	endtask
endmodule // lrss_host
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 0, reset = 1, cfg_wr = 0, stb;
	logic [7:0] a, d, v, cfg_d = 8'h00;
	logic [5:0] shf = 6'h00, x = 6'h00;
	wire [2:0] kind, ms, ss, sh;
	wire [5:0] ix, fc;
	wire [7:0] sa, sd;
	wire sw, dc, lk;
	wire [15:0] st = {2'h0, lk, dc, ms, ss, fc};
	logic [24:0] q[$];
	logic [2:0] k = 0;
	logic [7:0] c[9] = '{8'h01, 8'h24, 8'h40, 8'h41, 8'h80, 8'h00,
		8'hC0, 8'h25, 8'hFF};
	logic [31:0] r;
	int miscompares = 0, compares = 0, i;
	initial forever #2.5 ref_clk = ~ref_clk;
	lrss_host h(.ref_clk(ref_clk), .stb(stb), .a(a), .d(d));
	lrss_section_select DUT(.ref_clk(ref_clk), .reset(reset), .wr_stb(stb),
		.wr_addr(a), .wr_data(d), .cfg_wr(cfg_wr), .cfg_data(cfg_d),
		.show_frame(shf), .sec_kind(kind), .sec_index(ix), .sec_addr(sa),
		.sec_wr(sw), .sec_wdata(sd), .mem_conf(ms), .dc_enable(dc),
		.layout_locked(lk), .frame_count(fc), .set_count(ss), .show_set(sh));
	task chk_wr(input logic [24:0] g, input logic [24:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t write got %h want %h", $time, g, e);
		end
	endtask
	task chk_st(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t state got %h want %h", $time, g, e);
		end
	endtask
	task cfg(input logic [7:0] cv);
		@(negedge ref_clk);
		cfg_wr = 1;
		cfg_d = cv;
		@(negedge ref_clk);
		cfg_wr = 0;
	endtask
	// note goes in before the write, so the watcher never races it
	task note(input logic [7:0] na, input logic [7:0] nd);
		q.push_back({k, x, na, nd});
		h.wr(na, nd);
	endtask
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// outputs settle mid-cycle; an unexpected pulse is a mismatch
	always @(negedge ref_clk)
		if (sw === 1'b1)
		begin
			if (q.size() == 0)
				chk_wr({kind, ix, sa, sd}, 25'h1FFFFFF);
			else
				chk_wr({kind, ix, sa, sd}, q.pop_front());
		end
	initial
	begin
		r = $urandom(32'h029B);
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk) reset = 0;
		h.wr(8'h10, 8'h55); // no section yet: dropped
		cfg(8'h13); // layout 3 with dot correction
		@(negedge ref_clk) chk_st(st, {4'h1, 3'h3, 3'h3, 6'h17});
		for (i = 0; i < 40; i++)
		begin
			r = $urandom;
			v = c[r[19:16] % 9];
			if (v inside {8'h01, 8'h40, 8'h41, 8'h80, 8'hC0})
			begin
				k = v == 8'h01 ? 3'h1 : v[7:6] == 2'h1 ? 3'h2 :
					v[6] ? 3'h4 : 3'h3;
				x = {5'h00, v == 8'h41};
			end
			h.wr(8'hFD, v);
			if (k != 3'h0)
				note(r[15:8] & 8'h7F, r[7:0]);
			else
				h.wr(r[15:8] & 8'h7F, r[7:0]);
		end
		k = 3'h1;
		x = 6'h00;
		h.wr(8'hFD, 8'h01);
		note(8'h01, 8'h40);
		@(negedge ref_clk) chk_st({13'h0, sh}, 16'h0002);
		shf = 6'h20;
		@(negedge ref_clk) chk_st({13'h0, sh}, 16'h0000);
		cfg(8'h06); // locked: ignored
		@(negedge ref_clk) chk_st(st, {4'h3, 3'h3, 3'h3, 6'h17});
		@(negedge ref_clk) reset = 1;
		@(negedge ref_clk) chk_st(st, {4'h0, 3'h1, 3'h1, 6'h24});
		reset = 0;
		cfg(8'h06); // layout 6
		k = 3'h1;
		x = 6'h05;
		shf = 6'h05;
		h.wr(8'hFD, 8'h06);
		note(8'h01, 8'hA0);
		@(negedge ref_clk) chk_st({13'h0, sh}, 16'h0005);
		chk_st(st, {4'h2, 3'h6, 3'h6, 6'h06});
		chk_st({15'h0, q.size() == 0}, 16'h0001);
		end_sim;
	end
endmodule // testbench
`default_nettype wire
